// [rtl/slsm_pkg.sv]
// Package with constants and types of the safely limited speed monitor.
package slsm_pkg;
  localparam int FREQ_W = 16;
  localparam int RAMP_VAL_W = 8;
  localparam int WAIT_W = 16;
  localparam int CLK_HZ = 20000000;
  // Frequencies are in 0.1 Hz; ramp value is in 0.1 units, so the rate in 0.1 Hz/s is unit*value.
  localparam int RATE_SCALE_US = 1;
  localparam int TICK_PERIOD_MS = 1;
  localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_PERIOD_MS;
  localparam logic [1:0] RAMP_UNIT_1 = 2'h0;
  localparam logic [1:0] RAMP_UNIT_10 = 2'h1;
  localparam logic [1:0] RAMP_UNIT_100 = 2'h2;
  localparam logic [7:0] FAULT_CODE_NONE = 8'h00;
  localparam logic [7:0] FAULT_CODE_OVERSPEED = 8'h01;
  localparam logic [7:0] FAULT_CODE_CONFIG = 8'h02;
  typedef enum logic [2:0] {
    SLSM_IDLE,
    SLSM_LIMIT,
    SLSM_RAMP,
    SLSM_STOP_RAMP,
    SLSM_TORQUE_OFF
  } slsm_state_t;
endpackage

// [rtl/slsm_ramp.sv]
// Ramp generator that lowers a frequency at a programmable rate.
`timescale 1ns/10ps
module slsm_ramp #(
  parameter int FW = slsm_pkg::FREQ_W,
  parameter int TICK = slsm_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic load,
  input wire logic [FW-1:0] start_freq,
  input wire logic run,
  input wire logic [FW-1:0] target,
  input wire logic [1:0] ramp_unit,
  input wire logic [slsm_pkg::RAMP_VAL_W-1:0] ramp_value,
  output logic [FW-1:0] freq,
  output logic done
);
  typedef struct packed {
    logic [31:0] tick;
    logic [31:0] accum;
    logic [FW-1:0] freq;
  } slsm_ramp_st_t;
  slsm_ramp_st_t st_ff, nxt_st;
  logic [31:0] rate;
  always_comb begin
    // Rate per second in 0.1 Hz units times 0.1 value gives unit*value in 0.1 Hz/s.
    case (ramp_unit)
      slsm_pkg::RAMP_UNIT_10: rate = 32'(ramp_value) * 32'd10;
      slsm_pkg::RAMP_UNIT_100: rate = 32'(ramp_value) * 32'd100;
      default: rate = 32'(ramp_value);
    endcase
  end
  always_comb begin
    nxt_st = st_ff;
    if (load) begin
      nxt_st.freq = start_freq;
      nxt_st.tick = 32'h0;
      nxt_st.accum = 32'h0;
    end else if (run && st_ff.freq > target) begin
      if (st_ff.tick >= 32'(TICK - 1)) begin
        nxt_st.tick = 32'h0;
        // Millisecond steps: accumulate rate and subtract whole 0.1 Hz per 1000.
        nxt_st.accum = st_ff.accum + rate;
        if (nxt_st.accum >= 32'd1000) begin
          if (32'(st_ff.freq) - 32'(target) > nxt_st.accum / 32'd1000) begin
            nxt_st.freq = st_ff.freq - FW'(nxt_st.accum / 32'd1000);
          end else begin
            nxt_st.freq = target;
          end
          nxt_st.accum = nxt_st.accum % 32'd1000;
        end
      end else begin
        nxt_st.tick = st_ff.tick + 32'h1;
      end
    end
  end
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign freq = st_ff.freq;
  assign done = st_ff.freq <= target;
endmodule

// [rtl/slsm_top.sv]
// Safely limited speed monitor with emergency stop category 1 handling.
`timescale 1ns/10ps
module slsm_top #(
  parameter int FW = slsm_pkg::FREQ_W,
  parameter int TICK = slsm_pkg::TICK_CYCLES
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic limit_enable,
  input wire logic [2:0] limit_type,
  input wire logic estop_request,
  input wire logic estop_reset,
  input wire logic run_command,
  input wire logic signed [FW-1:0] stator_frequency,
  input wire logic signed [FW-1:0] reference_in,
  input wire logic [FW-1:0] speed_tolerance_threshold,
  input wire logic [FW-1:0] limited_speed_setpoint,
  input wire logic [FW-1:0] standstill_frequency_level,
  input wire logic [slsm_pkg::WAIT_W-1:0] below_standstill_grace_time,
  input wire logic [1:0] ramp_unit,
  input wire logic [slsm_pkg::RAMP_VAL_W-1:0] ramp_value,
  output logic signed [FW-1:0] reference_out,
  output logic torque_off_request,
  output logic controlled_stop_active,
  output logic safety_fault,
  output logic [7:0] safety_fault_code,
  output logic run_permitted,
  output logic limiter_active
);
  initial begin
    if (FW < 4 || TICK < 1) begin
      $error("slsm_top: unsupported parameters");
    end
  end

  typedef struct packed {
    slsm_pkg::slsm_state_t state;
    logic en_d;
    logic [FW-1:0] upper;
    logic [slsm_pkg::WAIT_W-1:0] wait_ms;
    logic [31:0] tick;
    logic grace;
    logic estop_latched;
    logic restart_blocked;
    logic run_d;
    logic signed [FW-1:0] ref_q;
    logic sto;
    logic ss1;
    logic fault;
    logic [7:0] code;
    logic permit;
    logic active;
  } slsm_st_t;

  slsm_st_t st_ff, nxt_st;

  function automatic logic [FW-1:0] mag(input logic signed [FW-1:0] v);
    mag = v[FW-1] ? FW'(-v) : FW'(v);
  endfunction

  function automatic logic signed [FW-1:0] clamp(input logic signed [FW-1:0] v,
                                                 input logic [FW-1:0] lo,
                                                 input logic [FW-1:0] hi);
    logic signed [FW:0] sv;
    sv = {v[FW-1], v};
    if (sv > $signed({2'b00, hi[FW-2:0]})) begin
      clamp = $signed(hi);
    end else if (sv < $signed({2'b00, lo[FW-2:0]})) begin
      clamp = $signed(lo);
    end else begin
      clamp = v;
    end
  endfunction

  logic [FW-1:0] sf_mag;
  logic activation;
  logic ramp_load;
  logic ramp_run;
  logic [FW-1:0] ramp_target;
  logic [FW-1:0] ramp_freq;
  logic ramp_done;
  logic type_23;
  logic type_123;
  logic type_456;
  logic run_edge;

  assign sf_mag = mag(stator_frequency);
  assign activation = limit_enable && !st_ff.en_d;
  assign type_23 = (limit_type == 3'd2) || (limit_type == 3'd3);
  assign type_123 = (limit_type == 3'd1) || type_23;
  assign type_456 = (limit_type >= 3'd4) && (limit_type <= 3'd6);
  assign run_edge = run_command && !st_ff.run_d;

  slsm_ramp #(
    .FW(FW),
    .TICK(TICK)
  ) u_ramp (
    .mclk(mclk),
    .resetn(resetn),
    .load(ramp_load),
    .start_freq(sf_mag),
    .run(ramp_run),
    .target(ramp_target),
    .ramp_unit(ramp_unit),
    .ramp_value(ramp_value),
    .freq(ramp_freq),
    .done(ramp_done)
  );

  always_comb begin
    ramp_load = 1'b0;
    ramp_run = 1'b0;
    ramp_target = limited_speed_setpoint;
    if ((estop_request && !st_ff.estop_latched && st_ff.state != slsm_pkg::SLSM_STOP_RAMP)
        || (activation && st_ff.state == slsm_pkg::SLSM_IDLE)) begin
      ramp_load = 1'b1;
    end
    if (st_ff.state == slsm_pkg::SLSM_STOP_RAMP) begin
      ramp_run = 1'b1;
      ramp_target = '0;
    end else if (st_ff.state == slsm_pkg::SLSM_RAMP) begin
      ramp_run = 1'b1;
      ramp_target = st_ff.upper;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.en_d = limit_enable;
    nxt_st.run_d = run_command;
    nxt_st.tick = st_ff.tick + 32'h1;
    if (st_ff.tick >= 32'(TICK - 1)) begin
      nxt_st.tick = 32'h0;
      if (st_ff.wait_ms != '0) begin
        nxt_st.wait_ms = st_ff.wait_ms - 1'b1;
      end
    end
    // A fresh run command edge clears the restart block once no stop is pending.
    if (run_edge && !st_ff.estop_latched && !st_ff.sto && !st_ff.ss1) begin
      nxt_st.restart_blocked = 1'b0;
    end
    if (estop_reset && !estop_request) begin
      // Reset only releases the latch; motion still waits for a new run edge.
      nxt_st.estop_latched = 1'b0;
    end
    case (st_ff.state)
      slsm_pkg::SLSM_IDLE: begin
        nxt_st.ref_q = reference_in;
        if (activation) begin
          nxt_st.active = 1'b1;
          nxt_st.wait_ms = below_standstill_grace_time;
          nxt_st.tick = 32'h0;
          nxt_st.grace = below_standstill_grace_time != '0;
          nxt_st.upper = limited_speed_setpoint;
          nxt_st.state = slsm_pkg::SLSM_LIMIT;
          if (limit_type == 3'd4 && speed_tolerance_threshold <= limited_speed_setpoint) begin
            nxt_st.fault = 1'b1;
            nxt_st.code = slsm_pkg::FAULT_CODE_CONFIG;
            nxt_st.sto = 1'b1;
            nxt_st.state = slsm_pkg::SLSM_TORQUE_OFF;
          end else if (limit_type == 3'd1) begin
            if (sf_mag > speed_tolerance_threshold) begin
              nxt_st.sto = 1'b1;
              nxt_st.fault = 1'b1;
              nxt_st.code = slsm_pkg::FAULT_CODE_OVERSPEED;
              nxt_st.state = slsm_pkg::SLSM_TORQUE_OFF;
            end else begin
              nxt_st.upper = sf_mag;
            end
          end else if (sf_mag > speed_tolerance_threshold && limit_type != 3'd2) begin
            if (limit_type == 3'd3) begin
              nxt_st.ss1 = 1'b1;
              nxt_st.state = slsm_pkg::SLSM_STOP_RAMP;
            end else if (limit_type == 3'd4) begin
              nxt_st.sto = 1'b1;
              nxt_st.fault = 1'b1;
              nxt_st.code = slsm_pkg::FAULT_CODE_OVERSPEED;
              nxt_st.state = slsm_pkg::SLSM_TORQUE_OFF;
            end else if (limit_type == 3'd5) begin
              nxt_st.state = slsm_pkg::SLSM_RAMP;
            end else begin
              nxt_st.upper = '0;
              nxt_st.state = slsm_pkg::SLSM_RAMP;
            end
          end else if (sf_mag > limited_speed_setpoint) begin
            nxt_st.state = slsm_pkg::SLSM_RAMP;
          end
        end
      end
      slsm_pkg::SLSM_RAMP: begin
        nxt_st.ref_q = stator_frequency[FW-1] ? -$signed(ramp_freq) : $signed(ramp_freq);
        if (type_123 && sf_mag >= speed_tolerance_threshold) begin
          nxt_st.sto = 1'b1;
          nxt_st.fault = 1'b1;
          nxt_st.code = slsm_pkg::FAULT_CODE_OVERSPEED;
          nxt_st.state = slsm_pkg::SLSM_TORQUE_OFF;
        end else if (ramp_done) begin
          // Ramp to zero ends in a held zero reference inside the limit window.
          nxt_st.upper = (st_ff.upper == '0) ? '0 : limited_speed_setpoint;
          nxt_st.state = slsm_pkg::SLSM_LIMIT;
        end
      end
      slsm_pkg::SLSM_LIMIT: begin
        if (limit_type == 3'd1) begin
          nxt_st.ref_q = clamp(reference_in, standstill_frequency_level, st_ff.upper);
        end else if (type_23) begin
          nxt_st.ref_q = clamp(reference_in, standstill_frequency_level, st_ff.upper);
        end else begin
          nxt_st.ref_q = (mag(reference_in) > st_ff.upper) ?
                         (reference_in[FW-1] ? -$signed(st_ff.upper) : $signed(st_ff.upper)) :
                         reference_in;
        end
        if (st_ff.grace && st_ff.wait_ms == '0) begin
          nxt_st.grace = 1'b0;
        end
        if (sf_mag >= speed_tolerance_threshold) begin
          nxt_st.sto = 1'b1;
          nxt_st.fault = 1'b1;
          nxt_st.code = slsm_pkg::FAULT_CODE_OVERSPEED;
          nxt_st.state = slsm_pkg::SLSM_TORQUE_OFF;
        end else if (type_123 && sf_mag <= standstill_frequency_level) begin
          if (!(type_23 && st_ff.grace && st_ff.wait_ms != '0)) begin
            nxt_st.sto = 1'b1;
            nxt_st.state = slsm_pkg::SLSM_TORQUE_OFF;
          end
        end else if (type_23) begin
          nxt_st.grace = 1'b0;
        end
        if (!limit_enable) begin
          nxt_st.active = 1'b0;
          nxt_st.state = slsm_pkg::SLSM_IDLE;
        end
      end
      slsm_pkg::SLSM_STOP_RAMP: begin
        // Power stays on while the stop ramp runs; torque goes off at standstill or once the ramp reaches zero.
        nxt_st.ref_q = stator_frequency[FW-1] ? -$signed(ramp_freq) : $signed(ramp_freq);
        if (sf_mag <= standstill_frequency_level || ramp_done) begin
          nxt_st.sto = 1'b1;
          nxt_st.ss1 = 1'b0;
          nxt_st.state = slsm_pkg::SLSM_TORQUE_OFF;
        end
      end
      default: begin
        nxt_st.ref_q = '0;
        nxt_st.restart_blocked = 1'b1;
        if (!limit_enable && !st_ff.estop_latched && !st_ff.fault && run_edge) begin
          nxt_st.sto = 1'b0;
          nxt_st.active = 1'b0;
          nxt_st.restart_blocked = 1'b0;
          nxt_st.state = slsm_pkg::SLSM_IDLE;
        end
      end
    endcase
    if (!limit_enable && st_ff.state == slsm_pkg::SLSM_RAMP && limit_type != 3'd6) begin
      nxt_st.state = slsm_pkg::SLSM_RAMP;
    end
    // The emergency stop is evaluated last so it overrides the decisions of every state except SLSM_STOP_RAMP and SLSM_TORQUE_OFF.
    if (estop_request) begin
      nxt_st.estop_latched = 1'b1;
      nxt_st.restart_blocked = 1'b1;
      if (st_ff.state != slsm_pkg::SLSM_STOP_RAMP && st_ff.state != slsm_pkg::SLSM_TORQUE_OFF) begin
        nxt_st.ss1 = 1'b1;
        nxt_st.state = slsm_pkg::SLSM_STOP_RAMP;
      end
    end
    nxt_st.permit = !nxt_st.estop_latched && !nxt_st.restart_blocked && !nxt_st.sto
                    && run_command;
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_ff <= '0;
      st_ff.state <= slsm_pkg::SLSM_IDLE;
      st_ff.restart_blocked <= 1'b1;
      st_ff.code <= slsm_pkg::FAULT_CODE_NONE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reference_out <= '0;
      torque_off_request <= 1'b0;
      controlled_stop_active <= 1'b0;
      safety_fault <= 1'b0;
      safety_fault_code <= slsm_pkg::FAULT_CODE_NONE;
      run_permitted <= 1'b0;
      limiter_active <= 1'b0;
    end else begin
      reference_out <= st_ff.permit ? st_ff.ref_q : '0;
      torque_off_request <= st_ff.sto;
      controlled_stop_active <= st_ff.ss1;
      safety_fault <= st_ff.fault;
      safety_fault_code <= st_ff.code;
      run_permitted <= st_ff.permit;
      limiter_active <= st_ff.active;
    end
  end
endmodule

// [bench/slsm_asserts.sv]
// Port checker of the safely limited speed monitor.
`timescale 1ns/10ps
module slsm_asserts #(
  parameter int FW = 16
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic limit_enable,
  input wire logic [2:0] limit_type,
  input wire logic estop_request,
  input wire logic run_command,
  input wire logic signed [FW-1:0] stator_frequency,
  input wire logic [FW-1:0] speed_tolerance_threshold,
  input wire logic [FW-1:0] limited_speed_setpoint,
  input wire logic [FW-1:0] standstill_frequency_level,
  input wire logic signed [FW-1:0] reference_out,
  input wire logic torque_off_request,
  input wire logic controlled_stop_active,
  input wire logic safety_fault,
  input wire logic [7:0] safety_fault_code,
  input wire logic run_permitted,
  input wire logic limiter_active
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  logic signed [FW:0] sp_pos;
  logic signed [FW:0] ref_x;
  logic t1;
  assign sp_pos = {1'b0, limited_speed_setpoint};
  assign ref_x = reference_out;
  assign t1 = limiter_active && limit_type == 3'h1 && !stator_frequency[FW-1];
  AST_REF_GATED: assert property (reference_out != 0 |-> run_permitted)
    else $error("reference without run permission");
  AST_FAULT_STICKY: assert property (safety_fault |=> safety_fault)
    else $error("fault cleared");
  AST_FAULT_TORQUE_OFF: assert property (safety_fault |-> torque_off_request)
    else $error("fault without torque off");
  AST_FAULT_CODE: assert property (safety_fault == (safety_fault_code != 8'h00))
    else $error("fault code disagrees with fault");
  AST_STOP_POWERED: assert property (controlled_stop_active |-> !torque_off_request)
    else $error("torque cut during controlled stop");
  AST_ESTOP_FIRST: assert property ($rose(estop_request) |->
    ##[1:3] (controlled_stop_active || torque_off_request))
    else $error("stop request not served");
  AST_RUN_NEEDS_CMD: assert property ($rose(run_permitted) |-> $past(run_command))
    else $error("restart without run command");
  AST_T1_OVERSPEED: assert property (t1 && stator_frequency >= speed_tolerance_threshold
    |-> ##[0:3] safety_fault)
    else $error("overspeed not faulted");
  AST_T1_STANDSTILL: assert property (t1 && stator_frequency <= standstill_frequency_level
    |-> ##[0:3] torque_off_request)
    else $error("standstill without torque off");
  AST_UPPER_BOUND: assert property ($past(limiter_active) && limiter_active &&
    limit_type inside {[3'h2:3'h6]} && $past(ref_x) <= sp_pos |-> ref_x <= sp_pos)
    else $error("reference above set point");
  AST_REVERSE_BOUND: assert property ($past(limiter_active) && limiter_active &&
    limit_type inside {[3'h4:3'h6]} && $past(ref_x) >= -sp_pos |-> ref_x >= -sp_pos)
    else $error("reverse reference above set point");
  AST_T4_CONFIG: assert property ($rose(limit_enable) && limit_type == 3'h4 &&
    !torque_off_request && speed_tolerance_threshold <= limited_speed_setpoint
    |-> ##[1:3] safety_fault)
    else $error("bad limits not faulted");
endmodule

// [bench/slsm_motor_model.sv]
// Behavioural motor and power stage driven by the monitor's reference.
`timescale 1ns/10ps
module slsm_motor_model #(
  parameter int STEP = 4
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic signed [15:0] reference_out,
  input wire logic torque_off_request,
  input wire logic hold,
  input wire logic push,
  output logic signed [15:0] stator_frequency
);
  localparam logic signed [15:0] ST = 16'(STEP);
  logic signed [15:0] tgt;
  // With torque removed the target is zero, so unless push drives it or hold freezes it the rotor can only coast to rest.
  assign tgt = torque_off_request ? 16'sh0000 : reference_out;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stator_frequency <= 16'sh0000;
    end else if (push) begin
      // An overhauling load may drive the shaft past any limited reference.
      stator_frequency <= stator_frequency + ST;
    end else if (!hold) begin
      if (tgt > stator_frequency + ST) begin
        stator_frequency <= stator_frequency + ST;
      end else if (tgt < stator_frequency - ST) begin
        stator_frequency <= stator_frequency - ST;
      end else begin
        stator_frequency <= tgt;
      end
    end
  end
endmodule

// [bench/slsm_top_tb.sv]
// Self-checking bench of the safely limited speed monitor.
`timescale 1ns/10ps
module slsm_top_tb;
  logic mclk, resetn, limit_enable, estop_request, estop_reset, run_command, hold, push;
  logic [2:0] limit_type;
  logic signed [15:0] stator_frequency, reference_in, reference_out;
  logic [15:0] thr, sp, ss, grace;
  logic [1:0] ramp_unit;
  logic [7:0] ramp_value, safety_fault_code;
  logic torque_off_request, controlled_stop_active, safety_fault, run_permitted, limiter_active;
  int bad_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  slsm_top #(.TICK(20)) i_dut (.mclk(mclk), .resetn(resetn), .limit_enable(limit_enable),
    .limit_type(limit_type), .estop_request(estop_request), .estop_reset(estop_reset),
    .run_command(run_command), .stator_frequency(stator_frequency),
    .reference_in(reference_in), .speed_tolerance_threshold(thr),
    .limited_speed_setpoint(sp), .standstill_frequency_level(ss),
    .below_standstill_grace_time(grace), .ramp_unit(ramp_unit), .ramp_value(ramp_value),
    .reference_out(reference_out), .torque_off_request(torque_off_request),
    .controlled_stop_active(controlled_stop_active), .safety_fault(safety_fault),
    .safety_fault_code(safety_fault_code), .run_permitted(run_permitted),
    .limiter_active(limiter_active));
  slsm_motor_model i_motor (.mclk(mclk), .resetn(resetn), .reference_out(reference_out),
    .torque_off_request(torque_off_request), .hold(hold), .push(push),
    .stator_frequency(stator_frequency));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 100000) begin
      bad_count++;
      end_of_test;
    end
  end
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Selector 0 watches the reference, 1 the torque-off request.
  task waitv(input int sel, input logic [15:0] v);
    logic [15:0] s;
    for (int i = 0; i < 8000; i++) begin
      @(negedge mclk);
      s = sel ? 16'(torque_off_request) : reference_out;
      if (s === v) break;
    end
    chk(s, v);
    // Return on a rising edge so that the next stimulus lands there too.
    @(posedge mclk);
  endtask
  task restart(input logic [15:0] ref_v);
    @(posedge mclk);
    resetn <= 1'b0;
    limit_enable <= 1'b0;
    run_command <= 1'b0;
    hold <= 1'b0;
    reference_in <= ref_v;
    cyc(5);
    resetn <= 1'b1;
    cyc(4);
    chk(16'(run_permitted), 16'h0000);
    run_command <= 1'b1;
    cyc(400);
    chk(16'(run_permitted), 16'h0001);
  endtask
  task activate(input logic [2:0] t);
    limit_type <= t;
    limit_enable <= 1'b1;
    cyc(4);
    chk(16'(limiter_active), 16'h0001);
  endtask
  task s_type1;
    restart(16'h01F4);
    activate(3'h1);
    reference_in <= 16'h0384;
    cyc(10);
    chk(reference_out, 16'h01F4);
    reference_in <= 16'h0000;
    waitv(0, 16'h0032);
    waitv(1, 16'h0001);
    chk(16'(safety_fault), 16'h0000);
    limit_enable <= 1'b0;
    cyc(20);
    chk(16'(run_permitted), 16'h0000);
    restart(16'h01F4);
    activate(3'h1);
    push <= 1'b1;
    waitv(1, 16'h0001);
    push <= 1'b0;
    chk(16'(safety_fault_code), 16'h0001);
  endtask
  task s_ramp(input logic [15:0] start);
    logic hi;
    // Above the tolerance threshold types 3 to 6 take their own activation branch; type 2 ramps and then faults.
    hi = start > 16'h02BC;
    for (int t = 2; t <= 6; t++) begin
      restart(start);
      activate(3'(t));
      if (hi && (t == 2 || t == 4)) begin
        waitv(1, 16'h0001);
        chk(16'(safety_fault_code), 16'h0001);
      end else if (hi && t == 3) begin
        chk(16'(controlled_stop_active), 16'h0001);
        waitv(1, 16'h0001);
      end else begin
        waitv(0, (hi && t == 6) ? 16'h0000 : 16'h012C);
        chk(16'(safety_fault), 16'h0000);
        reference_in <= -16'sh0384;
        cyc(10);
        chk(reference_out, (t > 3) ? ((hi && t == 6) ? 16'h0000 : -16'sh012C) : 16'h0032);
      end
    end
  endtask
  task s_misc;
    restart(16'h0064);
    thr <= 16'h00C8;
    activate(3'h4);
    waitv(1, 16'h0001);
    chk(16'(safety_fault_code), 16'h0002);
    thr <= 16'h02BC;
    restart(16'h0014);
    hold <= 1'b1;
    activate(3'h2);
    cyc(26);
    chk(16'(torque_off_request), 16'h0000);
    cyc(60);
    chk(16'(torque_off_request), 16'h0001);
    restart(16'h01F4);
    activate(3'h5);
    estop_request <= 1'b1;
    cyc(4);
    chk(16'(controlled_stop_active), 16'h0001);
    chk(16'(torque_off_request), 16'h0000);
    waitv(1, 16'h0001);
    estop_request <= 1'b0;
    limit_enable <= 1'b0;
    cyc(2);
    estop_reset <= 1'b1;
    cyc(1);
    estop_reset <= 1'b0;
    cyc(20);
    chk(16'(run_permitted), 16'h0000);
    run_command <= 1'b0;
    cyc(2);
    run_command <= 1'b1;
    cyc(6);
    chk(16'(run_permitted), 16'h0001);
  endtask
  initial begin
    {resetn, limit_enable, estop_request, estop_reset, run_command, hold, push} = 7'h00;
    limit_type = 3'h1;
    reference_in = 16'h0000;
    thr = 16'h02BC;
    sp = 16'h012C;
    ss = 16'h0032;
    grace = 16'h0003;
    ramp_unit = 2'h2;
    ramp_value = 8'hFF;
    s_type1;
    s_ramp(16'h01F4);
    s_ramp(16'h0320);
    s_misc;
    end_of_test;
  end
endmodule
bind slsm_top slsm_asserts #(.FW(FW)) i_chk (.mclk(mclk), .resetn(resetn),
  .limit_enable(limit_enable), .limit_type(limit_type), .estop_request(estop_request),
  .run_command(run_command), .stator_frequency(stator_frequency),
  .speed_tolerance_threshold(speed_tolerance_threshold),
  .limited_speed_setpoint(limited_speed_setpoint),
  .standstill_frequency_level(standstill_frequency_level), .reference_out(reference_out),
  .torque_off_request(torque_off_request), .controlled_stop_active(controlled_stop_active),
  .safety_fault(safety_fault), .safety_fault_code(safety_fault_code),
  .run_permitted(run_permitted), .limiter_active(limiter_active));
